// ### logic/fls_ctrl.sv
`timescale 1ns/1ps
`include "fls_regs.svh"
// How it works
// - ungated: flash at command, ends at limit
// - gated edge mode: strobe rise starts timed flash
// - gated level mode: pin sets length, limit cuts
// - flash only with mode 11 and output on
// - data fall while clock high is start
// - data rise while clock high is stop
// - data changes only while clock low
// - eight bit bytes plus ninth acknowledge bit
// - ack holds data low whole high phase
// - on read nack slave releases data line
// - all bytes most significant bit first
// - address 0110000, write first byte 60h
// - direction bit one selects read, 61h
// - matching address acked, others ignored
// - byte after write address loads pointer
// - pointer increments after each data byte
// - read starts at last stored pointer
// - slave sends bytes until master nacks
// - repeated start begins new transfer directly
// - works at 100kHz and 400kHz clocks
// - limit code 0..F gives 100..850ms steps 50
module fls_ctrl #(
   parameter int CLK_HZ     = 10000000,
   parameter int MS_CYCLES  = CLK_HZ / `FLS_MS_PER_S,
   parameter int CNT_W      = 24,
   parameter int BANK_DEPTH = 16
) (
   input  wire logic              REF_CLK_I,
   input  wire logic              SYS_RST_I,
   // avalon-mm slave
   input  wire logic [3:0]        AVS_ADDRESS_I,
   input  wire logic              AVS_READ_I,
   input  wire logic              AVS_WRITE_I,
   input  wire logic [31:0]       AVS_WRITEDATA_I,
   output logic      [31:0]       AVS_READDATA_O,
   output logic                   AVS_WAITREQUEST_O,
   // serial bus pins, open drain
   input  wire logic              SERIAL_CLOCK_LINE_I,
   output logic                   SERIAL_CLOCK_LINE_O,
   output logic                   SERIAL_CLOCK_LINE_OE_O,
   input  wire logic              SERIAL_DATA_LINE_I,
   output logic                   SERIAL_DATA_LINE_O,
   output logic                   SERIAL_DATA_LINE_OE_O,
   // flash trigger pin, flash output and register pointer
   input  wire logic              STROBE_I,
   output logic                   FLASH_ACTIVE_O,
   output fls_pkg::fls_byte_t     POINTER_O
);
   import fls_pkg::*;

   localparam int IDX_W = $clog2(BANK_DEPTH);

   // wraps the register pointer into the bank
   function automatic logic [IDX_W-1:0] bank_idx(input fls_byte_t p);
      bank_idx = p[IDX_W-1:0];
   endfunction

   // cycles of the flash limit for a four bit code
   function automatic logic [CNT_W-1:0] limit_cycles(input logic [3:0] c);
      int ms;
      ms = `FLS_TMO_BASE_MS + int'(c) * `FLS_TMO_STEP_MS;
      limit_cycles = CNT_W'(ms * MS_CYCLES);
   endfunction

   logic       [1:0]       mode_reg;
   logic                   out_on_reg;
   logic                   gate_en_reg;
   logic                   lvl_mode_reg;
   logic       [3:0]       tmo_reg;
   logic                   ack_reg;
   logic       [31:0]      rdata_reg;
   logic                   scl_m, scl_s, scl_d;
   logic                   sda_m, sda_s, sda_d;
   logic                   stb_m, stb_s, stb_d;
   logic                   scl_rise, scl_fall, bus_start, bus_stop;
   logic                   stb_rise;
   fls_bus_e               bus_reg;
   logic       [3:0]       bit_cnt_reg;
   fls_byte_t              shift_reg;
   fls_byte_t              ptr_reg;
   logic                   first_reg;
   logic                   ptr_phase_reg;
   logic                   rd_reg;
   logic                   oe_reg;
   fls_byte_t              bank [BANK_DEPTH];
   logic                   bank_we;
   fls_flash_e             fl_reg;
   logic       [CNT_W-1:0] cnt_reg;
   logic                   flash_sel, flash_sel_d;
   logic                   limit_hit;
   logic                   avs_req, avs_take;
   logic       [31:0]      status_word;

   // avalon: one wait cycle, then the request is taken
   assign avs_req           = AVS_READ_I | AVS_WRITE_I;
   assign AVS_WAITREQUEST_O = avs_req & ~ack_reg;
   assign avs_take          = avs_req & ack_reg;
   assign AVS_READDATA_O    = rdata_reg;

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= avs_req & ~ack_reg;
      end
   end

   // status word reflects the sequencer and the bus slave
   always_comb begin
      status_word = 32'h0;
      status_word[`FLS_STAT_ACTIVE] = (fl_reg == FL_ON);
      status_word[`FLS_STAT_BUSY]   = (bus_reg != BUS_IDLE);
      status_word[`FLS_STAT_PTR_HI:`FLS_STAT_PTR_LO] = ptr_reg;
   end

   // read data is latched in the wait cycle
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         rdata_reg <= 32'h0;
      end else if (AVS_READ_I && !ack_reg) begin
         case (AVS_ADDRESS_I)
            `FLS_OFS_CTRL: begin
               rdata_reg <= 32'h0;
               rdata_reg[`FLS_CTRL_MODE_HI:`FLS_CTRL_MODE_LO] <= mode_reg;
               rdata_reg[`FLS_CTRL_OUT_ON]   <= out_on_reg;
               rdata_reg[`FLS_CTRL_GATE_EN]  <= gate_en_reg;
               rdata_reg[`FLS_CTRL_LVL_MODE] <= lvl_mode_reg;
               rdata_reg[`FLS_CTRL_TMO_HI:`FLS_CTRL_TMO_LO] <= tmo_reg;
            end
            `FLS_OFS_STATUS: begin
               rdata_reg <= status_word;
            end
            default: begin
               rdata_reg <= 32'h0; // unmapped reads as zero
            end
         endcase
      end
   end

   // control register write
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         mode_reg     <= `FLS_RST_MODE;
         out_on_reg   <= 1'b0;
         gate_en_reg  <= 1'b0;
         lvl_mode_reg <= 1'b0;
         tmo_reg      <= `FLS_RST_TMO;
      end else if (avs_take && AVS_WRITE_I
                   && AVS_ADDRESS_I == `FLS_OFS_CTRL) begin
         mode_reg <= AVS_WRITEDATA_I[`FLS_CTRL_MODE_HI:`FLS_CTRL_MODE_LO];
         out_on_reg   <= AVS_WRITEDATA_I[`FLS_CTRL_OUT_ON];
         gate_en_reg  <= AVS_WRITEDATA_I[`FLS_CTRL_GATE_EN];
         lvl_mode_reg <= AVS_WRITEDATA_I[`FLS_CTRL_LVL_MODE];
         tmo_reg <= AVS_WRITEDATA_I[`FLS_CTRL_TMO_HI:`FLS_CTRL_TMO_LO];
      end
   end

   // pin synchronisers; third stage only for edge detection
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         {scl_m, scl_s, scl_d} <= 3'h7;
         {sda_m, sda_s, sda_d} <= 3'h7;
         {stb_m, stb_s, stb_d} <= 3'h0;
      end else begin
         {scl_m, scl_s, scl_d} <= {SERIAL_CLOCK_LINE_I, scl_m, scl_s};
         {sda_m, sda_s, sda_d} <= {SERIAL_DATA_LINE_I, sda_m, sda_s};
         {stb_m, stb_s, stb_d} <= {STROBE_I, stb_m, stb_s};
      end
   end

   // bus events; data edges while clock high are conditions
   assign scl_rise  = scl_s & ~scl_d;
   assign scl_fall  = ~scl_s & scl_d;
   assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
   assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
   assign stb_rise  = stb_s & ~stb_d;

   // serial slave: sample on clock rise, drive after clock fall
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         bus_reg       <= BUS_IDLE;
         bit_cnt_reg   <= 4'h0;
         shift_reg     <= `FLS_RST_BYTE;
         ptr_reg       <= `FLS_RST_BYTE;
         first_reg     <= 1'b0;
         ptr_phase_reg <= 1'b0;
         rd_reg        <= 1'b0;
         oe_reg        <= 1'b0;
      end else if (bus_stop) begin
         bus_reg <= BUS_IDLE;
         oe_reg  <= 1'b0;
      end else if (bus_start) begin
         bus_reg     <= BUS_RX;
         bit_cnt_reg <= 4'h0;
         first_reg   <= 1'b1;
         oe_reg      <= 1'b0;
      end else begin
         case (bus_reg)
            BUS_RX: begin
               if (scl_rise) begin
                  shift_reg   <= {shift_reg[6:0], sda_s};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == `FLS_BYTE_BITS) begin
                  if (first_reg) begin
                     if (shift_reg[7:1] == `FLS_BUS_ADDR) begin
                        rd_reg        <= shift_reg[0];
                        ptr_phase_reg <= ~shift_reg[0];
                        oe_reg        <= 1'b1;
                        bus_reg       <= BUS_ACK;
                     end else begin
                        bus_reg <= BUS_IDLE;
                     end
                  end else begin
                     if (ptr_phase_reg) begin
                        ptr_reg <= shift_reg;
                     end else begin
                        ptr_reg <= ptr_reg + 8'h1;
                     end
                     ptr_phase_reg <= 1'b0;
                     oe_reg        <= 1'b1;
                     bus_reg       <= BUS_ACK;
                  end
                  first_reg <= 1'b0;
               end
            end
            BUS_ACK: begin
               // ack held from one clock fall to the next
               if (scl_fall) begin
                  bit_cnt_reg <= 4'h0;
                  if (rd_reg) begin
                     shift_reg <= bank[bank_idx(ptr_reg)];
                     ptr_reg   <= ptr_reg + 8'h1;
                     oe_reg    <= ~bank[bank_idx(ptr_reg)][7];
                     bus_reg   <= BUS_TX;
                  end else begin
                     oe_reg  <= 1'b0;
                     bus_reg <= BUS_RX;
                  end
               end
            end
            BUS_TX: begin
               if (scl_rise) begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt_reg == `FLS_BYTE_BITS) begin
                     oe_reg  <= 1'b0;
                     bus_reg <= BUS_RACK;
                  end else begin
                     shift_reg <= {shift_reg[6:0], 1'b0};
                     oe_reg    <= ~shift_reg[6];
                  end
               end
            end
            BUS_RACK: begin
               if (scl_rise) begin
                  first_reg <= ~sda_s; // master ack seen
                  if (sda_s) begin
                     bus_reg <= BUS_IDLE;
                  end
               end else if (scl_fall && first_reg) begin
                  first_reg   <= 1'b0;
                  bit_cnt_reg <= 4'h0;
                  shift_reg   <= bank[bank_idx(ptr_reg)];
                  ptr_reg     <= ptr_reg + 8'h1;
                  oe_reg      <= ~bank[bank_idx(ptr_reg)][7];
                  bus_reg     <= BUS_TX;
               end
            end
            default: begin
               bus_reg <= BUS_IDLE; // idle also parks here
               oe_reg  <= 1'b0;
            end
         endcase
      end
   end

   // data byte written at the ack decision of a write transfer
   assign bank_we = (bus_reg == BUS_RX) && scl_fall && !bus_stop
                    && !bus_start && bit_cnt_reg == `FLS_BYTE_BITS
                    && !first_reg && !ptr_phase_reg;

   // register bank storage
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         for (int i = 0; i < BANK_DEPTH; i++) begin
            bank[i] <= `FLS_RST_BYTE;
         end
      end else if (bank_we) begin
         bank[bank_idx(ptr_reg)] <= shift_reg;
      end
   end

   // open drain: only ever pull low; clock line never driven
   assign SERIAL_DATA_LINE_O     = 1'b0;
   assign SERIAL_DATA_LINE_OE_O  = oe_reg;
   assign SERIAL_CLOCK_LINE_O    = 1'b0;
   assign SERIAL_CLOCK_LINE_OE_O = 1'b0;
   assign POINTER_O              = ptr_reg;

   // flash is selected only by mode 11 with output on
   assign flash_sel = (mode_reg == `FLS_MODE_FLASH) && out_on_reg;
   assign limit_hit = (cnt_reg >= limit_cycles(tmo_reg) - CNT_W'(1));

   // flash sequencer with the limit timer
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         fl_reg  <= FL_IDLE;
         cnt_reg <= '0;
      end else if (!flash_sel) begin
         fl_reg  <= FL_IDLE;
         cnt_reg <= '0;
      end else begin
         case (fl_reg)
            FL_IDLE: begin
               cnt_reg <= '0;
               if (gate_en_reg) begin
                  fl_reg <= FL_ARMED;
               end else if (!flash_sel_d) begin
                  fl_reg <= FL_ON;
               end
            end
            FL_ARMED: begin
               cnt_reg <= '0;
               if (!gate_en_reg) begin
                  fl_reg <= FL_DONE;
               end else if (lvl_mode_reg ? stb_s : stb_rise) begin
                  fl_reg <= FL_ON;
               end
            end
            FL_ON: begin
               cnt_reg <= cnt_reg + CNT_W'(1);
               if (limit_hit) begin
                  fl_reg <= FL_DONE;
               end else if (gate_en_reg && lvl_mode_reg && !stb_s) begin
                  fl_reg <= FL_ARMED;
               end
            end
            FL_DONE: begin
               cnt_reg <= '0;
               // gated modes re-arm once the pin is low again
               if (gate_en_reg && !stb_s) begin
                  fl_reg <= FL_ARMED;
               end
            end
            default: begin
               fl_reg <= FL_IDLE;
            end
         endcase
      end
   end

   // flash output and last selection, both from flops
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         flash_sel_d    <= 1'b0;
         FLASH_ACTIVE_O <= 1'b0;
      end else begin
         flash_sel_d    <= flash_sel;
         FLASH_ACTIVE_O <= (fl_reg == FL_ON) && flash_sel;
      end
   end
endmodule

// ### logic/fls_regs.svh
`ifndef FLS_REGS_SVH
`define FLS_REGS_SVH

// avalon register byte offsets
`define FLS_OFS_CTRL        4'h0
`define FLS_OFS_STATUS      4'h4
// ctrl field positions
`define FLS_CTRL_MODE_LO    0
`define FLS_CTRL_MODE_HI    1
`define FLS_CTRL_OUT_ON     2
`define FLS_CTRL_GATE_EN    3
`define FLS_CTRL_LVL_MODE   4
`define FLS_CTRL_TMO_LO     8
`define FLS_CTRL_TMO_HI     11
// status field positions
`define FLS_STAT_ACTIVE     0
`define FLS_STAT_BUSY       1
`define FLS_STAT_PTR_LO     8
`define FLS_STAT_PTR_HI     15
// reset values
`define FLS_RST_MODE        2'h0
`define FLS_RST_TMO         4'hf
`define FLS_RST_BYTE        8'h00
// flash mode code in the mode field
`define FLS_MODE_FLASH      2'h3
// seven bit bus address of the slave
`define FLS_BUS_ADDR        7'h30
// bits per byte on the serial bus
`define FLS_BYTE_BITS       4'h8
// flash limit: base and step in milliseconds
`define FLS_TMO_BASE_MS     100
`define FLS_TMO_STEP_MS     50
`define FLS_MS_PER_S        1000

`endif

// ### logic/fls_pkg.sv
package fls_pkg;
   // serial slave states
   typedef enum logic [4:0] {
      BUS_IDLE = 5'b00001,
      BUS_RX   = 5'b00010,
      BUS_ACK  = 5'b00100,
      BUS_TX   = 5'b01000,
      BUS_RACK = 5'b10000
   } fls_bus_e;
   // flash sequencer states
   typedef enum logic [3:0] {
      FL_IDLE  = 4'b0001,
      FL_ARMED = 4'b0010,
      FL_ON    = 4'b0100,
      FL_DONE  = 4'b1000
   } fls_flash_e;
   typedef logic [7:0] fls_byte_t;
endpackage

// ### tb/fls_ctrl_sva.sv
`timescale 1ns/1ps
`include "fls_regs.svh"
module fls_ctrl_sva #(
   parameter int MS_CYCLES = 10
) (
   input  wire logic       REF_CLK_I,
   input  wire logic       SYS_RST_I,
   input  wire logic       AVS_READ_I,
   input  wire logic       AVS_WRITE_I,
   input  wire logic       AVS_WAITREQUEST_O,
   input  wire logic       SERIAL_CLOCK_LINE_I,
   input  wire logic       SERIAL_CLOCK_LINE_OE_O,
   input  wire logic       SERIAL_DATA_LINE_I,
   input  wire logic       SERIAL_DATA_LINE_O,
   input  wire logic       SERIAL_DATA_LINE_OE_O,
   input  wire logic       FLASH_ACTIVE_O,
   input  wire logic [7:0] POINTER_O
);
   localparam int LIM_MAX = 850 * MS_CYCLES;
   logic [3:0] pos_reg;
   logic       first_reg;
   logic       rd_reg;
   logic [7:0] sh_reg;
   int         fl_cnt_reg;
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   // bit slot in the byte; a start condition restarts the first byte
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I || (SERIAL_CLOCK_LINE_I && $past(SERIAL_CLOCK_LINE_I)
                        && $fell(SERIAL_DATA_LINE_I))) begin
         pos_reg <= 4'h0;
         first_reg <= 1'b1;
      end else if ($rose(SERIAL_CLOCK_LINE_I)) begin
         pos_reg <= (pos_reg == 4'h8) ? 4'h0 : pos_reg + 4'h1;
         sh_reg <= {sh_reg[6:0], SERIAL_DATA_LINE_I};
         if (pos_reg == 4'h8) first_reg <= 1'b0;
         if (first_reg && pos_reg == 4'h7) rd_reg <= SERIAL_DATA_LINE_I;
      end
   end
   // cycles the flash has been on so far
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I || !FLASH_ACTIVE_O) fl_cnt_reg <= 0;
      else fl_cnt_reg <= fl_cnt_reg + 1;
   end
   property p_flash_lim;
      FLASH_ACTIVE_O |-> fl_cnt_reg < LIM_MAX;
   endproperty
   a_flash_lim: assert property (p_flash_lim)
      else $error("flash longer than the longest limit");
   property p_oe_low;
      $changed(SERIAL_DATA_LINE_OE_O) |-> !SERIAL_CLOCK_LINE_I;
   endproperty
   a_oe_low: assert property (p_oe_low)
      else $error("data drive changed while clock high");
   property p_ack_hold;
      $rose(SERIAL_CLOCK_LINE_I) && SERIAL_DATA_LINE_OE_O
         |=> SERIAL_DATA_LINE_OE_O [*3];
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("data drive dropped during clock high");
   property p_addr;
      $rose(SERIAL_CLOCK_LINE_I) && first_reg && pos_reg == 4'h8
         |-> SERIAL_DATA_LINE_OE_O == (sh_reg[7:1] == `FLS_BUS_ADDR);
   endproperty
   a_addr: assert property (p_addr)
      else $error("address acknowledge wrong");
   property p_nack;
      $rose(SERIAL_CLOCK_LINE_I) && rd_reg && !first_reg
         && pos_reg == 4'h8 && SERIAL_DATA_LINE_I
         |=> !SERIAL_DATA_LINE_OE_O [*8];
   endproperty
   a_nack: assert property (p_nack)
      else $error("data line not released after nack");
   property p_wait;
      $rose(AVS_READ_I) || $rose(AVS_WRITE_I)
         |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
   endproperty
   a_wait: assert property (p_wait)
      else $error("register access not one wait state");
   property p_od;
      !SERIAL_DATA_LINE_O && !SERIAL_CLOCK_LINE_OE_O;
   endproperty
   a_od: assert property (p_od)
      else $error("slave drives clock or drives data high");
   property p_rst;
      disable iff (1'b0) SYS_RST_I |=> !FLASH_ACTIVE_O && POINTER_O == 8'h00;
   endproperty
   a_rst: assert property (p_rst)
      else $error("reset state wrong");
   c_flash: cover property ($fell(FLASH_ACTIVE_O));
   c_ack: cover property ($rose(SERIAL_DATA_LINE_OE_O) && first_reg);
   c_nack: cover property (rd_reg && !first_reg && $rose(SERIAL_CLOCK_LINE_I)
                           && pos_reg == 4'h8 && SERIAL_DATA_LINE_I);
endmodule

// ### tb/fls_mst.sv
`timescale 1ns/1ps
// two-wire bus master; lines are open drain, 1 means released
module fls_mst (
   input  wire logic       clk_i,
   input  wire logic       sda_i,
   output logic            scl_o,
   output logic            sda_o,
   output logic [8:0]      rx_o,
   output logic            rx_stb_o
);
   int qc = 7;
   // idle bus, both lines high
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      rx_o = 9'h000;
      rx_stb_o = 1'b0;
   end
   // quarter bit time; qc 7 is fast rate, 25 standard rate
   task automatic q();
      repeat (qc) @(posedge clk_i);
   endtask
   // also serves as repeated start from a low clock
   task automatic start();
      sda_o <= 1'b1;
      q();
      scl_o <= 1'b1;
      q();
      sda_o <= 1'b0;
      q();
      scl_o <= 1'b0;
      q();
   endtask
   task automatic stop();
      sda_o <= 1'b0;
      q();
      scl_o <= 1'b1;
      q();
      sda_o <= 1'b1;
      q();
   endtask
   // eight bits msb first then the acknowledge slot, line seen mid-high
   task automatic xfer(input logic [8:0] tx);
      logic [8:0] r;
      for (int i = 8; i >= 0; i--) begin
         sda_o <= tx[i];
         q();
         scl_o <= 1'b1;
         q();
         r[i] = sda_i;
         q();
         scl_o <= 1'b0;
         q();
      end
      rx_o <= r;
      rx_stb_o <= 1'b1;
      @(posedge clk_i);
      rx_stb_o <= 1'b0;
   endtask
endmodule

// ### tb/fls_ctrl_tb.sv
`timescale 1ns/1ps
module fls_ctrl_tb;
   import fls_pkg::*;
   localparam int MSC = 10;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  adr = 4'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic        strobe = 1'b0;
   logic [31:0] rdat;
   logic        wq, fl, scl_oe, scl_do, sda_oe, sda_do, m_scl, m_sda, stb;
   logic [8:0]  mrx;
   fls_byte_t   ptr;
   logic [7:0]  d0, d1;
   logic [31:0] q_av[$];
   logic [8:0]  q_sr[$];
   int          q_fl[$];
   int          miscompares = 0;
   int          n_checks = 0;
   int          fl_len = 0;
   int          n;
   wire scl_w = m_scl & !(scl_oe & !scl_do);
   wire sda_w = m_sda & !(sda_oe & !sda_do);
   always #50 clk = !clk;
   fls_ctrl #(.MS_CYCLES(MSC)) u_dut (.REF_CLK_I(clk), .SYS_RST_I(rst),
      .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq),
      .SERIAL_CLOCK_LINE_I(scl_w), .SERIAL_CLOCK_LINE_O(scl_do),
      .SERIAL_CLOCK_LINE_OE_O(scl_oe), .SERIAL_DATA_LINE_I(sda_w),
      .SERIAL_DATA_LINE_O(sda_do), .SERIAL_DATA_LINE_OE_O(sda_oe),
      .STROBE_I(strobe), .FLASH_ACTIVE_O(fl), .POINTER_O(ptr));
   fls_mst u_mst (.clk_i(clk), .sda_i(sda_w), .scl_o(m_scl), .sda_o(m_sda),
      .rx_o(mrx), .rx_stb_o(stb));
   task automatic bad(input logic [31:0] g, input logic [31:0] e);
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
   endtask
   task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) bad(g, e);
   endtask
   task automatic cmp9(input logic [8:0] g, input logic [8:0] e);
      n_checks++;
      if (g !== e) bad(32'(g), 32'(e));
   endtask
   // register access, held until waitrequest is seen low
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
      adr <= a;
      rd <= !w;
      wr <= w;
      wd <= d;
      @(posedge clk);
      while (wq !== 1'b0) @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] e);
      q_av.push_back(e);
      av(1'b0, a, 32'h0);
   endtask
   task automatic sx(input logic [8:0] tx, input logic [8:0] e);
      q_sr.push_back(e);
      u_mst.xfer(tx);
   endtask
   // byte written by the master, acknowledged by the slave
   task automatic wb(input logic [7:0] b);
      sx({b, 1'b1}, {b, 1'b0});
   endtask
   // byte read from the slave, then ack (0) or nack (1)
   task automatic rb(input logic [7:0] e, input logic nk);
      sx({8'hff, nk}, {e, nk});
   endtask
   task automatic pulse(input int w);
      strobe <= 1'b1;
      repeat (w) @(posedge clk);
      strobe <= 1'b0;
      repeat (60) @(posedge clk);
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // monitors: take the oldest expectation when a result shows
   always @(posedge clk) begin
      if (rd && wq === 1'b0)
         cmp32(rdat, q_av.size() ? q_av.pop_front() : 32'hbad0bad0);
      if (stb === 1'b1)
         cmp9(mrx, q_sr.size() ? q_sr.pop_front() : 9'h1aa);
      if (fl === 1'b1) fl_len++;
      else if (fl_len != 0) begin
         cmp32(32'(fl_len), q_fl.size() ? 32'(q_fl.pop_front()) : 32'h0);
         fl_len = 0;
      end
   end
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      results();
   end
   initial begin
      d0 = 8'($urandom(90563));
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdc(4'h0, 32'h0000_0f00);
      rdc(4'h8, 32'h0);
      rdc(4'h4, 32'h0);
      done("registers");
      // write across the bank wrap, then a pointer-only write
      u_mst.start();
      wb(8'h60);
      wb(8'h0f);
      wb(d0);
      wb(d1);
      u_mst.stop();
      rdc(4'h4, 32'h0000_1100);
      u_mst.start();
      wb(8'h60);
      wb(8'h10);
      u_mst.stop();
      u_mst.start();
      wb(8'h61);
      rb(d1, 1'b0);
      rb(8'h00, 1'b1);
      u_mst.stop();
      // pointer write, repeated start, read at the slower rate
      u_mst.qc = 25;
      u_mst.start();
      wb(8'h60);
      wb(8'h0f);
      u_mst.start();
      wb(8'h61);
      rb(d0, 1'b0);
      rb(d1, 1'b1);
      u_mst.stop();
      u_mst.qc = 7;
      u_mst.start();
      sx(9'h0c5, 9'h0c5);
      u_mst.stop();
      done("serial");
      av(1'b1, 4'h0, 32'h006);
      av(1'b1, 4'h0, 32'h003);
      repeat (300) @(posedge clk);
      q_fl.push_back(850 * MSC);
      av(1'b1, 4'h0, 32'hf07);
      repeat (8600) @(posedge clk);
      q_fl.push_back(150 * MSC);
      av(1'b1, 4'h0, 32'h10f);
      pulse(50);
      repeat (1600) @(posedge clk);
      av(1'b1, 4'h0, 32'h01f);
      n = 100 + int'($urandom % 400);
      q_fl.push_back(n);
      pulse(n);
      q_fl.push_back(100 * MSC);
      pulse(1200);
      av(1'b1, 4'h0, 32'h0);
      done("flash");
      results();
   end
endmodule
bind fls_ctrl fls_ctrl_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (
   .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .AVS_READ_I(AVS_READ_I),
   .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
   .SERIAL_CLOCK_LINE_I(SERIAL_CLOCK_LINE_I),
   .SERIAL_CLOCK_LINE_OE_O(SERIAL_CLOCK_LINE_OE_O),
   .SERIAL_DATA_LINE_I(SERIAL_DATA_LINE_I),
   .SERIAL_DATA_LINE_O(SERIAL_DATA_LINE_O),
   .SERIAL_DATA_LINE_OE_O(SERIAL_DATA_LINE_OE_O),
   .FLASH_ACTIVE_O(FLASH_ACTIVE_O), .POINTER_O(POINTER_O));
